// ==== core/irq_timer.sv ====
// Interval timer with five counters and interrupt priority encoder
//
// Behaviour
// - The encoder takes the two timer levels, three error-logic enables, video and network requests.
// - The combined serial-controller request enters the encoder at level 6.
// - Three active-low lines carry the encoded level of the requester to the processor.
// - Level 7 is the top level and is never masked by the processor.
// - The timer holds five independent 16-bit counters.
// - The timer counts at 4.9152 MHz, the oscillator of 19.6608 MHz divided down.
// - Address bit A01 selects whether a timer access reaches the data port or the control port.
// - Timer reads are qualified by the read strobe and writes by the write strobe.
// - The timer gives one level 7 request and four level 5 requests.
`timescale 1ns/1ps
module irq_timer
    import irq_timer_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire timer_bus_t bus,
    input wire ext_irq_t ext,
    output logic [CNT_W-1:0] rd_data,
    output logic timer_level7_request,
    output logic [3:0] timer_level5_request,
    output logic [2:0] priority_level_n
);
    logic [PHASE_W-1:0] phase_r, phase_nxt;
    logic tick_r, tick_nxt;
    logic [CNT_W-1:0] cnt_r [NUM_CNT];
    logic [CNT_W-1:0] cnt_nxt [NUM_CNT];
    logic [CNT_W-1:0] reload_r [NUM_CNT];
    logic [CNT_W-1:0] reload_nxt [NUM_CNT];
    logic [NUM_CNT-1:0] en_r, en_nxt;
    logic [NUM_CNT-1:0] req_r, req_nxt;
    logic [SEL_W-1:0] sel_r, sel_nxt;
    logic [CNT_W-1:0] rdata_r, rdata_nxt;
    logic [2:0] prio_n_r, prio_n_nxt;
    logic [2:0] lvl_in;
    logic [CNT_W-1:0] sel_cnt;

    function automatic logic sel_ok(input logic [SEL_W-1:0] s);
        return s < SEL_W'(NUM_CNT);
    endfunction : sel_ok

    function automatic logic [2:0] max_lvl(input logic [2:0] a,
                                           input logic [2:0] b);
        return (a > b) ? a : b;
    endfunction : max_lvl

    // Timer tick from a phase accumulator
    always_comb begin
        {tick_nxt, phase_nxt} = {1'b0, phase_r} + {1'b0, PHASE_INC};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= PHASE_RST;
            tick_r <= 1'b0;
        end else if (ce) begin
            phase_r <= phase_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign sel_cnt = sel_ok(sel_r) ? cnt_r[sel_r] : RDATA_RST;

    // Counters, reloads, request flags and bus port
    always_comb begin
        en_nxt = en_r;
        sel_nxt = sel_r;
        rdata_nxt = rdata_r;
        req_nxt = req_r;
        for (int i = 0; i < NUM_CNT; i++) begin
            cnt_nxt[i] = cnt_r[i];
            reload_nxt[i] = reload_r[i];
        end
        if (bus.rd_stb) begin
            if (bus.a01 == PORT_DATA) begin
                rdata_nxt = sel_cnt;
            end else begin
                rdata_nxt = {8'h00, en_r, sel_r};
            end
        end
        if (bus.wr_stb) begin
            if (bus.a01 == PORT_DATA) begin
                if (sel_ok(sel_r)) begin
                    reload_nxt[sel_r] = bus.wdata;
                    cnt_nxt[sel_r] = bus.wdata;
                end
            end else begin
                sel_nxt = bus.wdata[CTL_SEL_LSB +: SEL_W];
                if (sel_ok(sel_nxt)) begin
                    en_nxt[sel_nxt] = bus.wdata[CTL_EN_BIT];
                    if (bus.wdata[CTL_ACK_BIT]) begin
                        req_nxt[sel_nxt] = 1'b0;
                    end
                end
            end
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            if (tick_r && en_r[i]) begin
                if (cnt_r[i] == '0) begin
                    cnt_nxt[i] = reload_r[i];
                    req_nxt[i] = 1'b1;
                end else begin
                    cnt_nxt[i] = cnt_r[i] - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_r <= EN_RST;
            sel_r <= SEL_RST;
            rdata_r <= RDATA_RST;
            req_r <= REQ_RST;
            for (int i = 0; i < NUM_CNT; i++) begin
                cnt_r[i] <= CNT_RST;
                reload_r[i] <= RELOAD_RST;
            end
        end else if (ce) begin
            en_r <= en_nxt;
            sel_r <= sel_nxt;
            rdata_r <= rdata_nxt;
            req_r <= req_nxt;
            for (int i = 0; i < NUM_CNT; i++) begin
                cnt_r[i] <= cnt_nxt[i];
                reload_r[i] <= reload_nxt[i];
            end
        end
    end

    // Priority encoder, no latching of inputs
    always_comb begin
        lvl_in = LVL_NONE;
        for (int i = 0; i < 3; i++) begin
            if (ext.error_logic_int_enables[i]) begin
                lvl_in = max_lvl(lvl_in, LVL_ERR1 + 3'(i));
            end
        end
        if (ext.net_request) begin
            lvl_in = max_lvl(lvl_in, LVL_NET);
        end
        if (!ext.video_request_n) begin
            lvl_in = max_lvl(lvl_in, LVL_VIDEO);
        end
        if (|req_r[NUM_CNT-1:1]) begin
            lvl_in = max_lvl(lvl_in, LVL_TIMER5);
        end
        if (!ext.serial_ctrl_request_n) begin
            lvl_in = max_lvl(lvl_in, LVL_SERIAL);
        end
        if (req_r[LVL7_CNT]) begin
            lvl_in = LVL_TIMER7;
        end
        prio_n_nxt = ~lvl_in;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prio_n_r <= PRIO_N_RST;
        end else if (ce) begin
            prio_n_r <= prio_n_nxt;
        end
    end

    assign rd_data = rdata_r;
    assign timer_level7_request = req_r[LVL7_CNT];
    assign timer_level5_request = req_r[NUM_CNT-1:1];
    assign priority_level_n = prio_n_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic quiet_in;
    assign quiet_in = !(|req_r) && !(|ext.error_logic_int_enables) &&
        ext.video_request_n && !ext.net_request && ext.serial_ctrl_request_n;

    sequence serial_then_gone;
        ce && !ext.serial_ctrl_request_n ##1 ce && quiet_in;
    endsequence

    idle_level_zero_a: assert property (
        ce && quiet_in |=> priority_level_n == 3'h7)
        else $error("idle encoder not at level zero");
    serial_level_six_a: assert property (
        ce && !ext.serial_ctrl_request_n && !req_r[LVL7_CNT]
        |=> priority_level_n == 3'h1)
        else $error("serial request not at level six");
    nmi_top_level_a: assert property (
        ce && timer_level7_request |=> priority_level_n == 3'h0)
        else $error("level seven not on top");
    video_level_a: assert property (
        ce && !ext.video_request_n && ext.serial_ctrl_request_n &&
        !(|req_r) |=> priority_level_n == 3'h3)
        else $error("video request not at level four");
    no_latch_a: assert property (
        serial_then_gone |=> priority_level_n == 3'h7)
        else $error("encoder held a removed request");
    tick_rate_a: assert property (
        ce && tick_r ##1 ce |-> !tick_r)
        else $error("timer tick faster than half the clock");
    wrap_sets_req_a: assert property (
        ce && tick_r && en_r[LVL7_CNT] && cnt_r[LVL7_CNT] == '0 &&
        !bus.wr_stb |=> timer_level7_request &&
        cnt_r[LVL7_CNT] == $past(reload_r[LVL7_CNT]))
        else $error("counter wrap missed reload or request");
    data_read_a: assert property (
        ce && bus.rd_stb && bus.a01 == PORT_DATA |=>
        rd_data == $past(sel_cnt))
        else $error("data port read wrong count");
    data_write_a: assert property (
        ce && bus.wr_stb && bus.a01 == PORT_DATA && sel_ok(sel_r) &&
        !tick_r |=> reload_r[$past(sel_r)] == $past(bus.wdata))
        else $error("data port write not loaded");
    timer_five_level_a: assert property (
        ce && (|timer_level5_request) && !timer_level7_request &&
        ext.serial_ctrl_request_n |=> priority_level_n == 3'h2)
        else $error("timer level five request not encoded");
    ack_clears_a: assert property (
        ce && bus.wr_stb && bus.a01 == PORT_CTRL &&
        bus.wdata[CTL_ACK_BIT] && bus.wdata[CTL_SEL_LSB +: SEL_W] == 3'h0 &&
        !tick_r |=> !timer_level7_request)
        else $error("acknowledge left level seven request set");
endmodule : irq_timer

// ==== core/irq_timer_pkg.sv ====
// Constants and carrier types for the interrupt encoder and interval timer
package irq_timer_pkg;
    localparam int NUM_CNT = 5;
    localparam int CNT_W = 16;
    localparam int SEL_W = 3;
    localparam longint OSC_HZ = 64'd19660800;
    localparam longint OSC_DIV = 64'd4;
    localparam longint TIMER_HZ = OSC_HZ / OSC_DIV;
    localparam longint CLK_HZ = 64'd10000000;
    localparam int PHASE_W = 16;
    localparam logic [PHASE_W-1:0] PHASE_INC =
        PHASE_W'((TIMER_HZ * 64'd65536) / CLK_HZ);
    localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'hffff;
    localparam logic [CNT_W-1:0] RELOAD_RST = 16'hffff;
    localparam logic [CNT_W-1:0] RDATA_RST = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    localparam logic [NUM_CNT-1:0] EN_RST = 5'h00;
    localparam logic [NUM_CNT-1:0] REQ_RST = 5'h00;
    localparam logic [2:0] PRIO_N_RST = 3'h7;
    localparam int CTL_SEL_LSB = 0;
    localparam int CTL_EN_BIT = 3;
    localparam int CTL_ACK_BIT = 4;
    localparam logic PORT_DATA = 1'b0;
    localparam logic PORT_CTRL = 1'b1;
    localparam int LVL7_CNT = 0;
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_ERR1 = 3'h1;
    localparam logic [2:0] LVL_ERR2 = 3'h2;
    localparam logic [2:0] LVL_NET = 3'h3;
    localparam logic [2:0] LVL_ERR3 = 3'h3;
    localparam logic [2:0] LVL_VIDEO = 3'h4;
    localparam logic [2:0] LVL_TIMER5 = 3'h5;
    localparam logic [2:0] LVL_SERIAL = 3'h6;
    localparam logic [2:0] LVL_TIMER7 = 3'h7;

    typedef struct packed {
        logic rd_stb;
        logic wr_stb;
        logic a01;
        logic [CNT_W-1:0] wdata;
    } timer_bus_t;

    typedef struct packed {
        logic [2:0] error_logic_int_enables;
        logic video_request_n;
        logic net_request;
        logic serial_ctrl_request_n;
    } ext_irq_t;
endpackage : irq_timer_pkg

// ==== testbench/cpu_model.sv ====
// Processor side model decoding the encoded interrupt level
`timescale 1ns/1ps
module cpu_model
    import irq_timer_pkg::*;
(
    input wire logic [2:0] priority_level_n,
    input wire logic [2:0] mask,
    output logic [2:0] level,
    output logic taken
);
    assign level = ~priority_level_n;
    // Top level ignores the mask
    assign taken = (level == LVL_TIMER7) || (level > mask);
endmodule : cpu_model

// ==== testbench/irq_timer_tb.sv ====
// Self-checking bench for the interrupt encoder and interval timer
`timescale 1ns/1ps
module irq_timer_tb;
    import irq_timer_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    timer_bus_t bus = '0;
    ext_irq_t ext = 6'b000101;
    logic [2:0] mask = 3'h4;
    logic [CNT_W-1:0] rd_data;
    logic timer_level7_request;
    logic [3:0] timer_level5_request;
    logic [2:0] priority_level_n;
    logic [2:0] level;
    logic taken;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    // Rows: ext inputs then expected level
    localparam logic [8:0] ROWS [9] = '{9'b000101_000, 9'b001101_001,
        9'b010101_010, 9'b100101_011, 9'b000111_011, 9'b000001_100,
        9'b000100_110, 9'b111010_110, 9'b011101_010};
    irq_timer dut_u (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus), .ext(ext),
        .rd_data(rd_data), .timer_level7_request(timer_level7_request),
        .timer_level5_request(timer_level5_request),
        .priority_level_n(priority_level_n));
    cpu_model cpu_u (.priority_level_n(priority_level_n), .mask(mask),
        .level(level), .taken(taken));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic end_sim();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic rd, input logic wr, input logic a,
                      input logic [15:0] d);
        @(posedge clk);
        #10 bus = '{rd, wr, a, d};
        @(posedge clk);
        #10 bus.rd_stb = 1'b0;
        bus.wr_stb = 1'b0;
        @(posedge clk);
        #10;
    endtask : op
    task automatic wait_lvl(input logic [2:0] exp);
        int n;
        for (n = 0; n < 60 && level !== exp; n++) begin
            @(posedge clk);
            #10;
        end
    endtask : wait_lvl
    initial begin
        repeat (12) @(posedge clk);
        #10 chk({13'h0, priority_level_n}, 16'h0007);
        chk(rd_data, 16'h0000);
        nrst = 1'b1;
        foreach (ROWS[i]) begin
            ext = ROWS[i][8:3];
            repeat (2) @(posedge clk);
            #10 chk({13'h0, level}, {13'h0, ROWS[i][2:0]});
            chk({15'h0, taken}, {15'h0, ROWS[i][2:0] > 3'h4});
        end
        ext = 6'b000101;
        repeat (2) @(posedge clk);
        #10 chk({13'h0, level}, 16'h0000);
        $display("Encoder table done");
        op(1'b0, 1'b1, PORT_CTRL, 16'h0002);
        op(1'b0, 1'b1, PORT_DATA, 16'h1234);
        op(1'b1, 1'b0, PORT_CTRL, 16'h0000);
        chk(rd_data, 16'h0002);
        op(1'b1, 1'b0, PORT_DATA, 16'h0000);
        chk(rd_data, 16'h1234);
        op(1'b0, 1'b0, PORT_DATA, 16'h5555);
        op(1'b1, 1'b0, PORT_DATA, 16'h0000);
        chk(rd_data, 16'h1234);
        $display("Access test done");
        mask = 3'h7;
        op(1'b0, 1'b1, PORT_CTRL, 16'h0008);
        op(1'b0, 1'b1, PORT_DATA, 16'h0002);
        wait_lvl(3'h7);
        chk({15'h0, timer_level7_request}, 16'h0001);
        chk({13'h0, level}, 16'h0007);
        chk({15'h0, taken}, 16'h0001);
        op(1'b0, 1'b1, PORT_CTRL, 16'h0010);
        op(1'b0, 1'b1, PORT_CTRL, 16'h0009);
        op(1'b0, 1'b1, PORT_DATA, 16'h0002);
        wait_lvl(3'h5);
        chk({12'h0, timer_level5_request}, 16'h0001);
        chk({15'h0, timer_level7_request}, 16'h0000);
        ext.serial_ctrl_request_n = 1'b0;
        repeat (2) @(posedge clk);
        #10 chk({13'h0, level}, 16'h0006);
        $display("Timer test done");
        op(1'b0, 1'b1, PORT_CTRL, 16'h0005);
        op(1'b1, 1'b0, PORT_DATA, 16'h0000);
        chk(rd_data, 16'h0000);
        op(1'b1, 1'b0, PORT_CTRL, 16'h0000);
        chk(rd_data, 16'h0015);
        $display("Select range test done");
        ce = 1'b0;
        ext = 6'b000101;
        repeat (2) @(posedge clk);
        #10 chk({13'h0, level}, 16'h0006);
        ce = 1'b1;
        repeat (2) @(posedge clk);
        #10 chk({13'h0, level}, 16'h0005);
        $display("Enable test done");
        nrst = 1'b0;
        #10 chk({13'h0, priority_level_n}, 16'h0007);
        chk({12'h0, timer_level5_request}, 16'h0000);
        chk(rd_data, 16'h0000);
        repeat (2) @(posedge clk);
        #10 nrst = 1'b1;
        op(1'b1, 1'b0, PORT_CTRL, 16'h0000);
        chk(rd_data, 16'h0000);
        chk({13'h0, level}, 16'h0000);
        ext.serial_ctrl_request_n = 1'b0;
        @(posedge clk);
        #10 chk({13'h0, level}, 16'h0006);
        ext.serial_ctrl_request_n = 1'b1;
        repeat (2) @(posedge clk);
        #10 chk({13'h0, level}, 16'h0000);
        $display("Reset test done");
        end_sim();
    end
endmodule : irq_timer_tb
